// [sarcs_pkg.sv]
// Purpose: shared constants and types of the converter control block
// Assumes: AHB-Lite register access, 32-bit aligned words
// Notes: register fields are 16 bits wide, upper bus bits read zero
package sarcs_pkg;

  // --------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
  localparam logic [7:0] TRIG_BASE_OFS = 8'h40;

  // --------------------------------------------------------------
  // control field positions and reset values
  // --------------------------------------------------------------
  localparam int ON_BIT = 15;
  localparam int IDLE_STOP_BIT = 13;
  localparam int AUX_CLK_BIT = 12;
  localparam int GTRIG_BIT = 10;
  localparam int ALIGN_BIT = 8;
  localparam int EARLY_BIT = 7;
  localparam int ORDER_BIT = 6;
  localparam int SEQ_BIT = 5;
  localparam int FREE_BIT = 4;
  localparam int DIV_LSB = 0;
  localparam logic [15:0] CTRL_RESET = 16'h0003;
  localparam logic [15:0] CTRL_IMPL_MASK = 16'hb5f7;
  localparam logic [15:0] CTRL_LOCK_MASK = 16'h11f7;
  localparam logic [15:0] STAT_RESET = 16'h0000;
  localparam logic [4:0] TRIG_NONE = 5'h00;
  localparam logic [4:0] TRIG_SOFT = 5'h01;
  localparam logic [4:0] TRIG_GLOBAL = 5'h02;
  localparam logic [1:0] SAMPLE_CLKS = 2'h2;

  // --------------------------------------------------------------
  // types
  // --------------------------------------------------------------
  typedef struct packed {
    logic on;
    logic rsv14;
    logic stop_idle;
    logic aux_clk;
    logic rsv11;
    logic gtrig;
    logic rsv9;
    logic align;
    logic early;
    logic order;
    logic seq;
    logic free;
    logic rsv3;
    logic [2:0] div;
  } sarcs_ctrl_type;

  typedef struct packed {
    logic valid;
    logic [4:0] channel;
    logic [15:0] data;
  } sarcs_result_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FIRST = 3'b010,
    ST_SECOND = 3'b100
  } sarcs_state_type;

endpackage

// [sarcs_adc_ctrl.sv]
// Purpose: control and status logic of a paired 10-bit converter
// Assumes: one clock hclk, converter data supplied by the analog side
// Notes: pair conversions run one at a time, lowest pending pair first
`timescale 1ns/1ps
module sarcs_adc_ctrl #(
  parameter int NPAIR = 13,
  parameter int CONV_CLKS = 12
) (
  // bus clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // converter clock sources
  input wire logic pll_primary_clk,
  input wire logic pll_aux_clk,
  // device state and triggers
  input wire logic idle_mode,
  input wire logic [NPAIR-1:0] pair_hw_trigger,
  // analog side
  input wire logic [9:0] conv_data,
  output logic [NPAIR-1:0] ded_sampling,
  output logic shared_sampling,
  output logic [4:0] conv_channel,
  output logic converting,
  // results and interrupts
  output sarcs_pkg::sarcs_result_type result,
  output logic [NPAIR-1:0] pair_irq,
  output logic irq
);

  localparam int CW = $clog2(CONV_CLKS + 1);
  localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CLKS - 1);

  // --------------------------------------------------------------
  // bus slave
  // --------------------------------------------------------------
  logic take;
  logic wr_q;
  logic rd_q;
  logic [7:0] addr_q;
  logic [15:0] wdat;
  logic [31:0] rd_mux;
  logic [31:0] hrdata_q;

  assign take = hsel & hready & htrans[1];
  assign wdat = hwdata[15:0];
  assign hreadyout = ~rd_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_q <= take & hwrite;
      rd_q <= take & ~hwrite;
      if (take) begin
        addr_q <= haddr[7:0];
      end
    end
  end

  // read data loaded during the single wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_q) begin
      hrdata_q <= rd_mux;
    end
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  sarcs_pkg::sarcs_ctrl_type ctrl_q;
  logic [15:0] ctrl_wr;
  logic [NPAIR-1:0] rdy_q;
  logic [NPAIR-1:0] rdy_set;
  logic [NPAIR-1:0] irq_stat_q;
  logic [NPAIR-1:0] irq_mask_q;
  logic [4:0] trig_src_q [NPAIR];
  logic [5:0] trig_idx;

  assign trig_idx = addr_q[7:2] - sarcs_pkg::TRIG_BASE_OFS[7:2];

  // locked fields keep their value while the converter runs
  always_comb begin
    ctrl_wr = wdat;
    if (ctrl_q.on) begin
      ctrl_wr = (wdat & ~sarcs_pkg::CTRL_LOCK_MASK) |
                (16'(ctrl_q) & sarcs_pkg::CTRL_LOCK_MASK);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= sarcs_pkg::CTRL_RESET;
    end else if (wr_q && addr_q == sarcs_pkg::CTRL_OFS) begin
      ctrl_q <= ctrl_wr & sarcs_pkg::CTRL_IMPL_MASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdy_q <= NPAIR'(sarcs_pkg::STAT_RESET);
    end else if (wr_q && addr_q == sarcs_pkg::STAT_OFS) begin
      rdy_q <= (rdy_q & wdat[NPAIR-1:0]) | rdy_set;
    end else begin
      rdy_q <= rdy_q | rdy_set;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_q <= '0;
    end else if (wr_q && addr_q == sarcs_pkg::IRQ_STAT_OFS) begin
      irq_stat_q <= (irq_stat_q & ~wdat[NPAIR-1:0]) | pair_irq;
    end else begin
      irq_stat_q <= irq_stat_q | pair_irq;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_q <= '0;
    end else if (wr_q && addr_q == sarcs_pkg::IRQ_MASK_OFS) begin
      irq_mask_q <= wdat[NPAIR-1:0];
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  genvar gp;
  generate
    for (gp = 0; gp < NPAIR; gp++) begin : g_src
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          trig_src_q[gp] <= sarcs_pkg::TRIG_NONE;
        end else if (wr_q && trig_idx == 6'(gp)) begin
          trig_src_q[gp] <= wdat[4:0];
        end
      end
    end
  endgenerate

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (addr_q)
      sarcs_pkg::CTRL_OFS: rd_mux = {16'h0000, 16'(ctrl_q)};
      sarcs_pkg::STAT_OFS: rd_mux = 32'(rdy_q);
      sarcs_pkg::IRQ_STAT_OFS: rd_mux = 32'(irq_stat_q);
      sarcs_pkg::IRQ_MASK_OFS: rd_mux = 32'(irq_mask_q);
      default: begin
        for (int i = 0; i < NPAIR; i++) begin
          if (trig_idx == 6'(i)) begin
            rd_mux = 32'(trig_src_q[i]);
          end
        end
      end
    endcase
  end

  // --------------------------------------------------------------
  // converter clock
  // --------------------------------------------------------------
  logic pri_s1_q;
  logic pri_s2_q;
  logic aux_s1_q;
  logic aux_s2_q;
  logic src_prev_q;
  logic src_sel;
  logic src_edge;
  logic [2:0] div_cnt_q;
  logic run;
  logic conv_tick;

  assign run = ctrl_q.on & ~(ctrl_q.stop_idle & idle_mode);
  assign src_sel = ctrl_q.aux_clk ? aux_s2_q : pri_s2_q;
  assign src_edge = src_sel & ~src_prev_q;
  assign conv_tick = run & src_edge & (div_cnt_q == ctrl_q.div);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pri_s1_q <= 1'b0;
      pri_s2_q <= 1'b0;
      aux_s1_q <= 1'b0;
      aux_s2_q <= 1'b0;
      src_prev_q <= 1'b0;
    end else begin
      pri_s1_q <= pll_primary_clk;
      pri_s2_q <= pri_s1_q;
      aux_s1_q <= pll_aux_clk;
      aux_s2_q <= aux_s1_q;
      src_prev_q <= src_sel;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_q <= 3'h0;
    end else if (!run) begin
      div_cnt_q <= 3'h0;
    end else if (src_edge) begin
      div_cnt_q <= (div_cnt_q == ctrl_q.div) ? 3'h0 : div_cnt_q + 3'h1;
    end
  end

  // --------------------------------------------------------------
  // triggers
  // --------------------------------------------------------------
  logic gtrig_prev_q;
  logic gtrig_rise;
  logic [NPAIR-1:0] req;

  assign gtrig_rise = ctrl_q.gtrig & ~gtrig_prev_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gtrig_prev_q <= 1'b0;
    end else begin
      gtrig_prev_q <= ctrl_q.gtrig;
    end
  end

  generate
    for (gp = 0; gp < NPAIR; gp++) begin : g_req
      assign req[gp] = run &
        ((trig_src_q[gp] == sarcs_pkg::TRIG_GLOBAL & gtrig_rise) |
         (trig_src_q[gp] > sarcs_pkg::TRIG_GLOBAL & pair_hw_trigger[gp]));
    end
  endgenerate

  // --------------------------------------------------------------
  // conversion sequencer
  // --------------------------------------------------------------
  sarcs_pkg::sarcs_state_type state_q;
  logic [NPAIR-1:0] pend_q;
  logic [3:0] cur_pair_q;
  logic [CW-1:0] cnt_q;
  logic start_first;
  logic done_first;
  logic done_second;
  logic cur_odd;
  logic [NPAIR-1:0] cur_onehot;

  function automatic logic [3:0] lowest(input logic [NPAIR-1:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = NPAIR - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  assign start_first = run & (state_q == sarcs_pkg::ST_IDLE) & (|pend_q);
  assign done_first = conv_tick & (state_q == sarcs_pkg::ST_FIRST) &
                      (cnt_q == CONV_LAST);
  assign done_second = conv_tick & (state_q == sarcs_pkg::ST_SECOND) &
                       (cnt_q == CONV_LAST);
  assign cur_odd = (state_q == sarcs_pkg::ST_FIRST) ? ctrl_q.order
                                                     : ~ctrl_q.order;
  assign cur_onehot = {{(NPAIR-1){1'b0}}, 1'b1} << cur_pair_q;
  assign conv_channel = {cur_pair_q, cur_odd};
  assign converting = (state_q != sarcs_pkg::ST_IDLE);
  assign rdy_set = done_second ? cur_onehot : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_q <= '0;
    end else if (!ctrl_q.on) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q & ~(start_first ? NPAIR'(1) << lowest(pend_q)
                                        : '0)) | req;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= sarcs_pkg::ST_IDLE;
      cur_pair_q <= 4'h0;
      cnt_q <= '0;
    end else if (!ctrl_q.on) begin
      state_q <= sarcs_pkg::ST_IDLE;
      cnt_q <= '0;
    end else begin
      unique case (state_q)
        sarcs_pkg::ST_IDLE: begin
          if (start_first) begin
            state_q <= sarcs_pkg::ST_FIRST;
            cur_pair_q <= lowest(pend_q);
            cnt_q <= '0;
          end
        end
        sarcs_pkg::ST_FIRST: begin
          if (done_first) begin
            state_q <= sarcs_pkg::ST_SECOND;
            cnt_q <= '0;
          end else if (conv_tick) begin
            cnt_q <= cnt_q + CW'(1);
          end
        end
        sarcs_pkg::ST_SECOND: begin
          if (done_second) begin
            state_q <= sarcs_pkg::ST_IDLE;
            cnt_q <= '0;
          end else if (conv_tick) begin
            cnt_q <= cnt_q + CW'(1);
          end
        end
        default: state_q <= sarcs_pkg::ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------
  // results and pair interrupts
  // --------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result <= '0;
      pair_irq <= '0;
    end else begin
      result.valid <= done_first | done_second;
      if (done_first | done_second) begin
        result.channel <= conv_channel;
        result.data <= ctrl_q.align ? {conv_data, 6'h00}
                                    : {6'h00, conv_data};
      end
      pair_irq <= ((ctrl_q.early & done_first) |
                   (~ctrl_q.early & done_second)) ? cur_onehot : '0;
    end
  end

  // --------------------------------------------------------------
  // sample-and-hold control
  // --------------------------------------------------------------
  logic [1:0] ded_cnt_q [NPAIR];
  logic shared_defer_q;
  logic [1:0] sh_cnt_q;
  logic sh_start;

  generate
    for (gp = 0; gp < NPAIR; gp++) begin : g_ded
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ded_sampling[gp] <= 1'b0;
          ded_cnt_q[gp] <= 2'h0;
        end else if (!ctrl_q.on) begin
          ded_sampling[gp] <= 1'b0;
          ded_cnt_q[gp] <= 2'h0;
        end else if (ctrl_q.free) begin
          ded_sampling[gp] <= ~(req[gp] | pend_q[gp] |
            (converting & cur_pair_q == 4'(gp)));
        end else if (req[gp]) begin
          ded_sampling[gp] <= 1'b1;
          ded_cnt_q[gp] <= sarcs_pkg::SAMPLE_CLKS;
        end else if (conv_tick && ded_cnt_q[gp] != 2'h0) begin
          ded_cnt_q[gp] <= ded_cnt_q[gp] - 2'h1;
          ded_sampling[gp] <= (ded_cnt_q[gp] != 2'h1);
        end
      end
    end
  endgenerate

  // shared sampling start, sequential or alongside dedicated
  always_comb begin
    if (ctrl_q.seq) begin
      sh_start = ctrl_q.order ? start_first : done_first;
    end else begin
      sh_start = ((|req) & ~shared_sampling & ~converting) |
                 (start_first & shared_defer_q);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shared_defer_q <= 1'b0;
    end else if (!ctrl_q.on || ctrl_q.seq) begin
      shared_defer_q <= 1'b0;
    end else if ((|req) && (shared_sampling || converting)) begin
      shared_defer_q <= 1'b1;
    end else if (start_first) begin
      shared_defer_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shared_sampling <= 1'b0;
      sh_cnt_q <= 2'h0;
    end else if (!ctrl_q.on) begin
      shared_sampling <= 1'b0;
      sh_cnt_q <= 2'h0;
    end else if (sh_start) begin
      shared_sampling <= 1'b1;
      sh_cnt_q <= sarcs_pkg::SAMPLE_CLKS;
    end else if (conv_tick && sh_cnt_q != 2'h0) begin
      sh_cnt_q <= sh_cnt_q - 2'h1;
      shared_sampling <= (sh_cnt_q != 2'h1);
    end
  end

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  off_idle_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !ctrl_q.on |=> state_q == sarcs_pkg::ST_IDLE)
    else $error("sequencer active while converter off");

  idle_halt_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ctrl_q.stop_idle && idle_mode |=> !result.valid)
    else $error("conversion finished while idle halted");

  clock_select_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    conv_tick |-> (ctrl_q.aux_clk ? aux_s2_q && !src_prev_q
                                  : pri_s2_q && !src_prev_q))
    else $error("converter tick not from selected source");

  global_trig_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    run && gtrig_rise && trig_src_q[1] == sarcs_pkg::TRIG_GLOBAL
    |=> pend_q[1] || state_q == sarcs_pkg::ST_FIRST)
    else $error("global trigger did not start pair 1");

  result_align_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    result.valid |-> (ctrl_q.align ? result.data[5:0] == 6'h00
                                   : result.data[15:10] == 6'h00))
    else $error("result justification wrong");

  early_irq_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (|pair_irq) |-> $past(ctrl_q.early ? done_first : done_second))
    else $error("pair interrupt at wrong conversion");

  conv_order_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    state_q == sarcs_pkg::ST_FIRST |-> conv_channel[0] == ctrl_q.order)
    else $error("first converted input has wrong parity");

  ready_set_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (|rdy_set) |=> (rdy_q & $past(rdy_set)) == $past(rdy_set))
    else $error("ready flag lost on hardware set");

  ready_keep_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_q && addr_q == sarcs_pkg::STAT_OFS
    |=> (rdy_q & $past(rdy_q & wdat[NPAIR-1:0])) ==
        $past(rdy_q & wdat[NPAIR-1:0]))
    else $error("writing one cleared a ready flag");

  read_zero_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hreadyout |-> hrdata[31:16] == 16'h0000)
    else $error("unimplemented bits read nonzero");

  free_stop_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ctrl_q.on && ctrl_q.free && req[0] |=> !ded_sampling[0])
    else $error("free-running sampling did not stop");

  sample_end_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ctrl_q.on && !ctrl_q.free && !req[0] && $past(!req[0]) &&
    $fell(ded_sampling[0]) |-> $past(conv_tick))
    else $error("dedicated sampling ended off a converter clock");

endmodule

// [tb_top.sv]
// Purpose: self-checking bench of the converter control block
// Assumes: single word ahb-lite transfers, short conversions
// Notes: assertions live in the design files
`timescale 1ns/1ps
module tb_top;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic pclk = 1'b0;
  logic aclk = 1'b0;
  logic idle_mode = 1'b0;
  logic [12:0] hw_trig = 13'h0;
  logic [9:0] conv_data = 10'h2a5;
  sarcs_pkg::sarcs_result_type result;
  logic [12:0] pair_irq;
  logic irq;
  int fail_count = 0;
  int tests_run = 0;
  int res_count = 0;
  int irq_cnt = 0;
  int cyc = 0;
  logic [12:0] ded_s;
  logic sh_s;
  logic [4:0] chan;
  logic busy;

  sarcs_adc_ctrl #(.NPAIR(13), .CONV_CLKS(2)) sarcs_adc_ctrl_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pll_primary_clk(pclk), .pll_aux_clk(aclk),
    .idle_mode(idle_mode), .pair_hw_trigger(hw_trig),
    .conv_data(conv_data), .ded_sampling(ded_s), .shared_sampling(sh_s),
    .conv_channel(chan), .converting(busy), .result(result),
    .pair_irq(pair_irq), .irq(irq));

  // ------------------------------------------------------------
  // clocks and monitors
  // ------------------------------------------------------------
  initial begin
    forever #25 hclk = ~hclk;
  end
  initial begin
    forever #20 pclk = ~pclk;
  end
  initial begin
    forever #36 aclk = ~aclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (result.valid === 1'b1) res_count <= res_count + 1;
    if (pair_irq[1] === 1'b1) irq_cnt <= irq_cnt + 1;
  end

  // ------------------------------------------------------------
  // bus and compare tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus_cycle(input logic wr, input logic [7:0] a,
                           input logic [31:0] d, output logic [31:0] q);
    int n;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'b10;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 50) begin
      n++;
      @(posedge hclk);
    end
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 50) begin
      n++;
      @(posedge hclk);
    end
    q = hrdata;
    if (n >= 50) check("bus answer", 32'h1, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_cycle(1'b1, a, d, q);
  endtask

  task automatic rd_check(input string what, input logic [7:0] a,
                          input logic [31:0] exp);
    logic [31:0] q;
    bus_cycle(1'b0, a, 32'h0, q);
    check(what, exp, q);
    check("hresp", 32'h0, 32'(hresp));
  endtask

  task automatic wait_result(output sarcs_pkg::sarcs_result_type r);
    int n;
    n = 0;
    r = '0;
    while (n < 2000) begin
      @(posedge hclk);
      n++;
      if (result.valid === 1'b1) begin
        r = result;
        n = 3000;
      end
    end
    if (n < 3000) check("result wait", 32'h1, 32'h0);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic reset_and_regs();
    rd_check("ctrl reset", sarcs_pkg::CTRL_OFS, 32'h3);
    rd_check("stat reset", sarcs_pkg::STAT_OFS, 32'h0);
    wr(8'h20, 32'hffff_ffff);
    rd_check("unmapped", 8'h20, 32'h0);
    wr(sarcs_pkg::CTRL_OFS, 32'hffff_ffff);
    rd_check("ctrl ones", sarcs_pkg::CTRL_OFS, 32'hb5f7);
    wr(sarcs_pkg::CTRL_OFS, 32'h0);
    rd_check("ctrl locked", sarcs_pkg::CTRL_OFS, 32'h11f7);
    wr(sarcs_pkg::CTRL_OFS, 32'h0);
    rd_check("ctrl cleared", sarcs_pkg::CTRL_OFS, 32'h0);
  endtask

  task automatic run_pair(input logic odd1, input logic early,
                          input logic left);
    logic [31:0] c;
    logic [31:0] on;
    int n0;
    int i;
    sarcs_pkg::sarcs_result_type r;
    c = 32'h0;
    c[sarcs_pkg::ORDER_BIT] = odd1;
    c[sarcs_pkg::EARLY_BIT] = early;
    c[sarcs_pkg::ALIGN_BIT] = left;
    c[sarcs_pkg::AUX_CLK_BIT] = left;
    on = c | 32'h8000;
    n0 = irq_cnt;
    conv_data <= left ? 10'h35a : 10'h2a5;
    wr(sarcs_pkg::CTRL_OFS, c);
    wr(sarcs_pkg::CTRL_OFS, on);
    wr(sarcs_pkg::CTRL_OFS, on | 32'h0400);
    for (i = 0; i < 2; i++) begin
      wait_result(r);
      check("channel", {27'h0, 4'h1, odd1 ^ i[0]}, 32'(r.channel));
      check("data", left ? {16'h0, conv_data, 6'h0} : {22'h0, conv_data},
            32'(r.data));
      repeat (2) @(posedge hclk);
      check("pair irq", (early || i == 1) ? 32'h1 : 32'h0,
            32'(irq_cnt - n0));
    end
    rd_check("ready set", sarcs_pkg::STAT_OFS, 32'h2);
    wr(sarcs_pkg::STAT_OFS, 32'hffff_ffff);
    rd_check("ready kept", sarcs_pkg::STAT_OFS, 32'h2);
    wr(sarcs_pkg::STAT_OFS, 32'h0);
    rd_check("ready clear", sarcs_pkg::STAT_OFS, 32'h0);
    wr(sarcs_pkg::CTRL_OFS, c);
  endtask

  task automatic irq_test();
    rd_check("irq stat", sarcs_pkg::IRQ_STAT_OFS, 32'h2);
    @(posedge hclk);
    check("irq masked", 32'h0, 32'(irq));
    wr(sarcs_pkg::IRQ_MASK_OFS, 32'h2);
    @(posedge hclk);
    check("irq unmasked", 32'h1, 32'(irq));
    wr(sarcs_pkg::IRQ_STAT_OFS, 32'h2);
    @(posedge hclk);
    check("irq cleared", 32'h0, 32'(irq));
    rd_check("irq stat clr", sarcs_pkg::IRQ_STAT_OFS, 32'h0);
  endtask

  task automatic sampling();
    int t1;
    sarcs_pkg::sarcs_result_type r;
    wr(sarcs_pkg::TRIG_BASE_OFS, 32'h3);
    wr(sarcs_pkg::CTRL_OFS, 32'h0067);
    wr(sarcs_pkg::CTRL_OFS, 32'h8067);
    hw_trig <= 13'h0001;
    @(posedge hclk);
    hw_trig <= 13'h0000;
    @(posedge hclk);
    check("ded start", 32'h1, 32'(ded_s[0]));
    @(posedge hclk);
    check("busy", 32'h1, 32'(busy));
    check("channel out", 32'h1, 32'(chan));
    check("shared first", 32'h1, 32'(sh_s));
    wait_result(r);
    t1 = cyc;
    check("ded done", 32'h0, 32'(ded_s[0]));
    wait_result(r);
    check("second ch", 32'h0, 32'(r.channel));
    check("div span", 32'h1, 32'(cyc - t1 >= 32));
    wr(sarcs_pkg::CTRL_OFS, 32'h0);
    wr(sarcs_pkg::CTRL_OFS, 32'h0010);
    wr(sarcs_pkg::CTRL_OFS, 32'h8010);
    repeat (2) @(posedge hclk);
    check("free idle", 32'h1, 32'(ded_s[0]));
    hw_trig <= 13'h0001;
    @(posedge hclk);
    hw_trig <= 13'h0000;
    @(posedge hclk);
    check("free stop", 32'h0, 32'(ded_s[0]));
    check("shared with ded", 32'h1, 32'(sh_s));
    wait_result(r);
    wait_result(r);
    repeat (2) @(posedge hclk);
    check("free again", 32'h1, 32'(ded_s[0]));
    check("busy end", 32'h0, 32'(busy));
    wr(sarcs_pkg::CTRL_OFS, 32'h0);
  endtask

  task automatic dropped_triggers();
    int n0;
    n0 = res_count;
    wr(sarcs_pkg::CTRL_OFS, 32'h0400);
    wr(sarcs_pkg::CTRL_OFS, 32'h0);
    idle_mode <= 1'b1;
    wr(sarcs_pkg::CTRL_OFS, 32'h2000);
    wr(sarcs_pkg::CTRL_OFS, 32'ha000);
    wr(sarcs_pkg::CTRL_OFS, 32'ha400);
    repeat (200) @(posedge hclk);
    check("results dropped", 32'h0, 32'(res_count - n0));
    idle_mode <= 1'b0;
    wr(sarcs_pkg::CTRL_OFS, 32'h0);
  endtask

  // ------------------------------------------------------------
  // sequence and verdict
  // ------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    reset_and_regs();
    wr(sarcs_pkg::TRIG_BASE_OFS + 8'h4, 32'h2);
    run_pair(1'b0, 1'b0, 1'b0);
    irq_test();
    run_pair(1'b1, 1'b1, 1'b1);
    sampling();
    dropped_triggers();
    results();
  end

  initial begin
    #2000000;
    fail_count++;
    results();
  end
endmodule
